// ### hdl/ffs_defs.svh
// constants for the flag status register and command decoder
`ifndef FFS_DEFS_SVH
`define FFS_DEFS_SVH
// -------------------------------------------------------------
// flag bit positions
// -------------------------------------------------------------
`define FFS_BIT_READY    7
`define FFS_BIT_ESUSP    6
`define FFS_BIT_ERASE    5
`define FFS_BIT_PROG     4
`define FFS_BIT_SUPPLY   3
`define FFS_BIT_PSUSP    2
`define FFS_BIT_PROT     1
`define FFS_RST_READY    1'b1
`define FFS_RST_ERR      4'h0
// -------------------------------------------------------------
// command codes
// -------------------------------------------------------------
`define FFS_CMD_RD_FLAGS 8'h70
`define FFS_CMD_CLR      8'h50
`define FFS_CMD_RD_ID    8'hAF
`define FFS_CMD_RD_NVCR  8'hB5
`define FFS_CMD_FAST     8'h0B
`define FFS_CMD_DOUT     8'h3B
`define FFS_CMD_QOUT     8'h6B
`define FFS_CMD_DIO      8'hBB
`define FFS_CMD_QIO      8'hEB
`define FFS_CMD_PP       8'h02
`define FFS_CMD_DPP      8'hA2
`define FFS_CMD_XDPP     8'hD2
`define FFS_CMD_QPP      8'h32
`define FFS_CMD_XQPP     8'h12
`define FFS_CMD_SSE      8'h20
`define FFS_CMD_SE       8'hD8
`define FFS_CMD_BE       8'hC7
`define FFS_CMD_OTP_PGM  8'h42
// -------------------------------------------------------------
// frame counts
// -------------------------------------------------------------
`define FFS_CMD_BITS     5'h08
`define FFS_ADDR_BITS    5'h18
`define FFS_DUMMY_STD    4'h8
`define FFS_DUMMY_QUAD   4'hA
`define FFS_ID_BYTES     2'h3
`define FFS_ID_VALUE     24'h5AC301
`endif

// ### hdl/ffs_pkg.sv
// types shared by the flag status and command decoder files
package ffs_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_CMD   = 6'b000010,
    ST_ADDR  = 6'b000100,
    ST_DUMMY = 6'b001000,
    ST_DOUT  = 6'b010000,
    ST_SKIP  = 6'b100000
  } ffs_state_t;
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_RDFLG = 4'h1,
    OP_CLR   = 4'h2,
    OP_RDID  = 4'h3,
    OP_RDNV  = 4'h4,
    OP_FAST  = 4'h5,
    OP_DOUT  = 4'h6,
    OP_QOUT  = 4'h7,
    OP_DIO   = 4'h8,
    OP_QIO   = 4'h9,
    OP_PE    = 4'hA
  } ffs_op_t;
endpackage

// ### hdl/ffs_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ffs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ### hdl/ffs_sticky.sv
// sticky error bits, set wins over clear
`timescale 1ns/1ps
module ffs_sticky #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_next;
  // an event in the clearing cycle is kept
  assign q_next = set | (q & {W{~clr}});
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= q_next;
    end
  end
endmodule

// ### hdl/ffs_top.sv
// flag status register and serial command decoder
`timescale 1ns/1ps
`include "ffs_defs.svh"
module ffs_top
  import ffs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic [3:0]  DQ_IN,
  output logic      [3:0]  DQ_OUT,
  output logic      [3:0]  DQ_OE_N,
  input  wire logic        PROTO_DUAL,
  input  wire logic        PROTO_QUAD,
  input  wire logic [3:0]  DUMMY_CYCLES,
  input  wire logic [15:0] NVCR,
  input  wire logic        PE_BUSY,
  input  wire logic        REG_WR_BUSY,
  input  wire logic        ERASE_SUSP,
  input  wire logic        PROG_SUSP,
  input  wire logic        ERASE_FAIL,
  input  wire logic        PROG_FAIL,
  input  wire logic        PROG_ZERO_TO_ONE,
  input  wire logic        PROG_SUPPLY_HIGH_LEVEL,
  input  wire logic        PROG_PATTERN_64,
  input  wire logic        SUPPLY_INVALID,
  input  wire logic        PROT_FAULT,
  input  wire logic        OTP_LOCKED_PROG,
  output logic [7:0]       FLAGS,
  output logic             CMD_VALID,
  output logic [3:0]       CMD_OP,
  output logic [23:0]      CMD_ADDR,
  output logic             CMD_REJECT
);
  // -------------------------------------------------------------
  // pin sampling
  // -------------------------------------------------------------
  logic [5:0]  pins_s;
  logic        sck_s;
  logic        cs_n_s;
  logic [3:0]  dq_s;
  logic        sck_prev_reg;
  wire         sck_rise = sck_s & ~sck_prev_reg;
  wire         sck_fall = ~sck_s & sck_prev_reg;

  // select rides inverted so a cleared stage reads deselected
  ffs_sync #(.W(6)) u_sync (
    .clk (CLK),
    .rst (RST),
    .d   ({SCK, ~CS_N, DQ_IN}),
    .q   (pins_s)
  );
  assign sck_s  = pins_s[5];
  assign cs_n_s = ~pins_s[4];
  assign dq_s   = pins_s[3:0];

  // -------------------------------------------------------------
  // flag register
  // -------------------------------------------------------------
  logic        rdy_reg;
  logic        esusp_reg;
  logic        psusp_reg;
  logic [3:0]  err_q;
  logic [3:0]  err_set;
  logic        clr_err;
  logic        clr_pend_reg;
  wire         err_any = |err_q;

  // ready follows program/erase only; register writes ignored
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdy_reg   <= `FFS_RST_READY;
      esusp_reg <= 1'b0;
      psusp_reg <= 1'b0;
    end else begin
      rdy_reg   <= ~PE_BUSY;
      esusp_reg <= ERASE_SUSP;
      psusp_reg <= PROG_SUSP;
    end
  end

  // error causes, order erase, program, supply, protection
  assign err_set[3] = ERASE_FAIL;
  assign err_set[2] = PROG_FAIL | (PROG_ZERO_TO_ONE
                    & PROG_SUPPLY_HIGH_LEVEL
                    & PROG_PATTERN_64);
  assign err_set[1] = SUPPLY_INVALID & PE_BUSY;
  assign err_set[0] = PROT_FAULT | OTP_LOCKED_PROG;

  ffs_sticky #(.W(4)) u_err (
    .clk (CLK),
    .rst (RST),
    .set (err_set),
    .clr (clr_err),
    .q   (err_q)
  );

  // bit 0 is reserved and reads zero
  assign FLAGS = {rdy_reg, esusp_reg, err_q[3], err_q[2],
                  err_q[1], psusp_reg, err_q[0], 1'b0};

  // -------------------------------------------------------------
  // lane widths and decode
  // -------------------------------------------------------------
  ffs_state_t  state_reg;
  ffs_op_t     op_reg;
  ffs_op_t     dec_op;
  logic [23:0] in_reg;
  logic [4:0]  cnt_reg;
  logic [3:0]  dum_reg;
  logic [7:0]  osh_reg;
  logic [3:0]  obits_reg;
  logic [1:0]  idx_reg;

  wire         is_quad = PROTO_QUAD;
  wire         is_dual = PROTO_DUAL & ~PROTO_QUAD;
  wire         is_ext  = ~is_quad & ~is_dual;
  wire [2:0]   cmd_ln  = is_quad ? 3'h4 : (is_dual ? 3'h2 : 3'h1);
  wire [2:0]   addr_ln = (op_reg == OP_QIO) ? 3'h4 :
                         (op_reg == OP_DIO) ? 3'h2 : cmd_ln;
  wire [2:0]   ln      = (state_reg == ST_ADDR) ? addr_ln : cmd_ln;

  // msb first; lane count set by protocol, or by the dual/quad io op in the address phase
  wire [23:0]  in_next = (ln == 3'h4) ? {in_reg[19:0], dq_s} :
                         (ln == 3'h2) ? {in_reg[21:0], dq_s[1:0]} :
                                        {in_reg[22:0], dq_s[0]};
  wire [4:0]   cnt_next = cnt_reg + {2'b00, ln};
  wire [7:0]   cb       = in_next[7:0];

  wire         cb_pe = (cb == `FFS_CMD_PP)  || (cb == `FFS_CMD_DPP) ||
                       (cb == `FFS_CMD_XDPP) || (cb == `FFS_CMD_QPP) ||
                       (cb == `FFS_CMD_XQPP) || (cb == `FFS_CMD_SSE) ||
                       (cb == `FFS_CMD_SE)  || (cb == `FFS_CMD_BE)  ||
                       (cb == `FFS_CMD_OTP_PGM);

  // protocol-dependent code table; unknown codes fall to none
  assign dec_op =
    (cb == `FFS_CMD_RD_FLAGS)            ? OP_RDFLG :
    (cb == `FFS_CMD_CLR)                 ? OP_CLR   :
    (cb == `FFS_CMD_RD_ID && !is_ext)    ? OP_RDID  :
    (cb == `FFS_CMD_RD_NVCR)             ? OP_RDNV  :
    (cb == `FFS_CMD_FAST)  ? (is_dual ? OP_DIO :
                              is_quad ? OP_QIO : OP_FAST) :
    (cb == `FFS_CMD_DOUT && !is_quad)    ? (is_dual ? OP_DIO
                                                    : OP_DOUT) :
    (cb == `FFS_CMD_QOUT && !is_dual)    ? (is_quad ? OP_QIO
                                                    : OP_QOUT) :
    (cb == `FFS_CMD_DIO && !is_quad)     ? OP_DIO   :
    (cb == `FFS_CMD_QIO && !is_dual)     ? OP_QIO   :
    cb_pe                                ? OP_PE    : OP_NONE;

  wire         dec_out  = (dec_op == OP_RDFLG) || (dec_op == OP_RDID) ||
                          (dec_op == OP_RDNV);
  wire         dec_read = (dec_op >= OP_FAST) && (dec_op <= OP_QIO);
  // zero selects the default dummy count of the protocol
  wire [3:0]   dum_sel  = (DUMMY_CYCLES != 4'h0) ? DUMMY_CYCLES :
                          is_quad ? `FFS_DUMMY_QUAD : `FFS_DUMMY_STD;

  // -------------------------------------------------------------
  // output byte selection
  // -------------------------------------------------------------
  wire [1:0]   idx_next = (idx_reg == 2'h3) ? 2'h3 : idx_reg + 2'h1;
  wire [23:0]  id_word  = `FFS_ID_VALUE;  // arbitrary value
  wire [7:0]   nv_byte  = (idx_next == 2'h1) ? NVCR[15:8] : 8'h00;
  wire [7:0]   id_byte  = (idx_next == 2'h1) ? id_word[15:8] :
                          (idx_next == 2'h2) ? id_word[7:0]  : 8'h00;
  wire [7:0]   nxt_byte = (op_reg == OP_RDFLG) ? FLAGS :
                          (op_reg == OP_RDNV)  ? nv_byte : id_byte;
  wire [7:0]   first_b  = (dec_op == OP_RDFLG) ? FLAGS :
                          (dec_op == OP_RDNV)  ? NVCR[7:0] :
                                                 id_word[23:16];
  // single lane answers on DQ1, wider ones from DQ0 up
  wire [3:0]   pin_val  = (cmd_ln == 3'h4) ? osh_reg[7:4] :
                          (cmd_ln == 3'h2) ? {2'b00, osh_reg[7:6]} :
                                             {2'b00, osh_reg[7], 1'b0};
  wire [3:0]   pin_oe_n = (cmd_ln == 3'h4) ? 4'h0 :
                          (cmd_ln == 3'h2) ? 4'hC : 4'hD;
  wire [3:0]   obits_nx = obits_reg + {1'b0, cmd_ln};
  wire         byte_end = (obits_nx == 4'h8);
  wire         id_done  = (op_reg == OP_RDID) &&
                          (idx_reg == `FFS_ID_BYTES);

  // -------------------------------------------------------------
  // frame sequencer
  // -------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
    end
  end

  // chip select high ends every frame and releases the lines
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg    <= ST_IDLE;
      op_reg       <= OP_NONE;
      in_reg       <= 24'h000000;
      cnt_reg      <= 5'h00;
      dum_reg      <= 4'h0;
      clr_pend_reg <= 1'b0;
    end else if (cs_n_s) begin
      state_reg    <= ST_IDLE;
      clr_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_CMD;
          cnt_reg   <= 5'h00;
          op_reg    <= OP_NONE;
        end
        ST_CMD: begin
          if (sck_rise) begin
            in_reg  <= in_next;
            cnt_reg <= cnt_next;
            if (cnt_next == `FFS_CMD_BITS) begin
              op_reg  <= dec_op;
              cnt_reg <= 5'h00;
              // register commands answer with no address
              if (dec_out) begin
                state_reg <= ST_DOUT;
              end else if (dec_read) begin
                state_reg <= ST_ADDR;
              end else begin
                state_reg    <= ST_SKIP;
                clr_pend_reg <= (dec_op == OP_CLR);
              end
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            in_reg  <= in_next;
            cnt_reg <= cnt_next;
            if (cnt_next == `FFS_ADDR_BITS) begin
              state_reg <= ST_DUMMY;
              dum_reg   <= dum_sel;
            end
          end
        end
        ST_DUMMY: begin
          if (sck_rise) begin
            dum_reg <= dum_reg - 4'h1;
            if (dum_reg == 4'h1) begin
              state_reg <= ST_SKIP;
            end
          end
        end
        ST_DOUT: begin
          state_reg <= ST_DOUT;
        end
        ST_SKIP: begin
          state_reg <= ST_SKIP;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // clear acts only when the frame closes after a whole code
  assign clr_err = cs_n_s & clr_pend_reg;

  // -------------------------------------------------------------
  // command report to the array controller
  // -------------------------------------------------------------
  wire         pe_hit   = (state_reg == ST_CMD) && sck_rise &&
                          (cnt_next == `FFS_CMD_BITS) &&
                          (dec_op == OP_PE);
  wire         read_hit = (state_reg == ST_DUMMY) && sck_rise &&
                          (dum_reg == 4'h1) && !cs_n_s;

  // a pending error marks a new program/erase command as refused; reads are never refused
  always_ff @(posedge CLK) begin
    if (RST) begin
      CMD_VALID  <= 1'b0;
      CMD_OP     <= 4'h0;
      CMD_ADDR   <= 24'h000000;
      CMD_REJECT <= 1'b0;
    end else begin
      CMD_VALID <= (pe_hit && !cs_n_s) || read_hit;
      if ((pe_hit && !cs_n_s) || read_hit) begin
        CMD_OP     <= pe_hit ? OP_PE : op_reg;
        CMD_ADDR   <= pe_hit ? 24'h000000 : in_reg;
        CMD_REJECT <= pe_hit & err_any;
      end
    end
  end

  // -------------------------------------------------------------
  // data output, shifted on falling serial clock
  // -------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      osh_reg   <= 8'h00;
      obits_reg <= 4'h0;
      idx_reg   <= 2'h0;
      DQ_OUT    <= 4'h0;
      DQ_OE_N   <= 4'hF;
    end else if (state_reg != ST_DOUT || cs_n_s) begin
      DQ_OE_N   <= 4'hF;
      obits_reg <= 4'h0;
      idx_reg   <= 2'h0;
      if (state_reg == ST_CMD) begin
        osh_reg <= first_b;
      end
    end else if (sck_fall) begin
      DQ_OUT  <= pin_val;
      DQ_OE_N <= id_done ? 4'hF : pin_oe_n;
      if (byte_end) begin
        // flags repeat for as long as the host clocks
        osh_reg   <= nxt_byte;
        obits_reg <= 4'h0;
        idx_reg   <= idx_next;
      end else begin
        osh_reg   <= osh_reg << cmd_ln;
        obits_reg <= obits_nx;
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  AST_READY_BUSY: assert property (
    @(posedge CLK) disable iff (RST)
    PE_BUSY ##1 PE_BUSY |-> !FLAGS[`FFS_BIT_READY])
    else $error("ready bit high while busy");
  AST_REGWR_READY: assert property (
    @(posedge CLK) disable iff (RST)
    (REG_WR_BUSY && !PE_BUSY) |=> FLAGS[`FFS_BIT_READY])
    else $error("register write changed ready bit");
  AST_SUSP_AUTO: assert property (
    @(posedge CLK) disable iff (RST)
    (!ERASE_SUSP && !PROG_SUSP) |=>
    !FLAGS[`FFS_BIT_ESUSP] && !FLAGS[`FFS_BIT_PSUSP])
    else $error("suspend bit did not clear");
  AST_ESUSP: assert property (
    @(posedge CLK) disable iff (RST)
    $rose(ERASE_SUSP) |=> FLAGS[`FFS_BIT_ESUSP])
    else $error("erase suspend not shown");
  AST_PSUSP: assert property (
    @(posedge CLK) disable iff (RST)
    $rose(PROG_SUSP) |=> FLAGS[`FFS_BIT_PSUSP])
    else $error("program suspend not shown");
  AST_ERASE_ERR: assert property (
    @(posedge CLK) disable iff (RST)
    ERASE_FAIL |=> FLAGS[`FFS_BIT_ERASE])
    else $error("erase error not set");
  AST_PROG_ERR: assert property (
    @(posedge CLK) disable iff (RST)
    (PROG_ZERO_TO_ONE && PROG_SUPPLY_HIGH_LEVEL && PROG_PATTERN_64)
    |=> FLAGS[`FFS_BIT_PROG])
    else $error("program error not set");
  AST_SUPPLY_ERR: assert property (
    @(posedge CLK) disable iff (RST)
    (SUPPLY_INVALID && PE_BUSY) |=> FLAGS[`FFS_BIT_SUPPLY])
    else $error("supply error not set");
  AST_PROT_ERR: assert property (
    @(posedge CLK) disable iff (RST)
    OTP_LOCKED_PROG |=> FLAGS[`FFS_BIT_PROT])
    else $error("protection error not set");
  AST_ERR_HOLD: assert property (
    @(posedge CLK) disable iff (RST)
    (FLAGS[`FFS_BIT_ERASE] && !clr_err) |=> FLAGS[`FFS_BIT_ERASE])
    else $error("error bit dropped without clear");
  AST_REJECT: assert property (
    @(posedge CLK) disable iff (RST)
    (pe_hit && !cs_n_s && err_any) |=> CMD_VALID && CMD_REJECT)
    else $error("command under error not refused");
  AST_RSVD_ZERO: assert property (
    @(posedge CLK) disable iff (RST)
    (state_reg == ST_SKIP) |=> (DQ_OE_N == 4'hF) && !FLAGS[0])
    else $error("skip frame drove lines");
endmodule

// ### verification/ffs_spi_host.sv
// serial host model driving the flag block's link pins
`timescale 1ns/1ps
module ffs_spi_host (
  input  wire logic       clk,
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      dq,
  input  wire logic [3:0] dq_out,
  input  wire logic [3:0] dq_oe_n
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    dq   = 4'h0;
  end
  // half of the 800 ns link period
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // select with setup before the first rise
  task automatic open_frame();
    cs_n <= 1'b0;
    half();
  endtask
  // link clock stands low between frames; lines change so none look held
  task automatic close_frame();
    sck <= 1'b0;
    half();
    cs_n <= 1'b1;
    dq   <= ~dq;
    repeat (8) @(posedge clk);
  endtask
  // msb first, lanes bits per rise, idle lanes toggle
  task automatic send(input logic [31:0] v, input int bits, input int lanes);
    logic [31:0] s;
    logic [3:0]  t;
    s = v << (32 - bits);
    for (int i = 0; i < bits; i += lanes) begin
      t = ~dq;
      for (int k = 0; k < lanes; k++) t[lanes-1-k] = s[31-k];
      s = s << lanes;
      sck <= 1'b0;
      dq  <= t;
      half();
      sck <= 1'b1;
      half();
    end
  endtask
  // one byte back; single-line mode answers on line 1
  // a released line reads inverted, so a missing drive shows up
  task automatic recv(output logic [7:0] b, input int lanes);
    b = 8'h00;
    for (int i = 0; i < 8; i += lanes) begin
      sck <= 1'b0;
      dq  <= ~dq;
      half();
      sck <= 1'b1;
      half();
      if (lanes == 1) b = {b[6:0], dq_out[1] ^ dq_oe_n[1]};
      else for (int k = lanes - 1; k >= 0; k--)
        b = {b[6:0], dq_out[k] ^ dq_oe_n[k]};
    end
  endtask
endmodule

// ### verification/tb_flash_flag_status_and_command_decode.sv
// self-checking bench for the flag register and command decoder
`timescale 1ns/1ps
`include "ffs_defs.svh"
module tb_flash_flag_status_and_command_decode;
  import ffs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, dual = 1'b0, quad = 1'b0;
  logic rwb = 1'b0, es = 1'b0, ps = 1'b0, lrej = 1'b0, oe_seen = 1'b0;
  logic [3:0] dummy = 4'h0;
  logic [15:0] nvcr = 16'h0000;
  logic [8:0] fin = 9'h000;
  logic sck, cs_n, cvalid, crej;
  logic [3:0] dq_in, dq_out, dq_oe_n, cop;
  logic [7:0] flags, b;
  logic [23:0] cadr;
  logic [31:0] seed = 32'h0000E594, r;
  int err_count = 0, samples_checked = 0, vcnt = 0, n, ln;
  // error inputs per case and the error bits they must leave
  logic [8:0] ev [8] = '{9'h080, 9'h040, 9'h038, 9'h030, 9'h104, 9'h004,
                         9'h002, 9'h001};
  logic [7:0] ee [8] = '{8'h20, 8'h10, 8'h10, 8'h00, 8'h08, 8'h00, 8'h02,
                         8'h02};
  // fast read cases: code, op, protocol, address lanes, dummy setting
  logic [7:0] fc [9] = '{8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hEB, 8'h0B,
                         8'h0B, 8'h6B};
  logic [3:0] fo [9] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9, 4'h5, 4'h8,
                         4'h9};
  int fp [9] = '{0, 0, 0, 0, 0, 2, 0, 1, 2};
  int fa [9] = '{1, 1, 1, 2, 4, 4, 1, 2, 4};
  logic [3:0] fd [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'h0,
                         4'h0};
  // answer-or-ignore cases: code, protocol, lines driven
  logic [7:0] rc [6] = '{8'hAF, 8'hAF, 8'h3B, 8'h6B, 8'h70, 8'hFF};
  int rp [6] = '{0, 1, 2, 1, 2, 0};
  logic rd [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

  always #50 clk = ~clk;

  ffs_top DUT (
    .CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .DQ_IN(dq_in),
    .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .PROTO_DUAL(dual),
    .PROTO_QUAD(quad), .DUMMY_CYCLES(dummy), .NVCR(nvcr),
    .PE_BUSY(fin[8]), .REG_WR_BUSY(rwb), .ERASE_SUSP(es), .PROG_SUSP(ps),
    .ERASE_FAIL(fin[7]), .PROG_FAIL(fin[6]), .PROG_ZERO_TO_ONE(fin[5]),
    .PROG_SUPPLY_HIGH_LEVEL(fin[4]), .PROG_PATTERN_64(fin[3]),
    .SUPPLY_INVALID(fin[2]), .PROT_FAULT(fin[1]),
    .OTP_LOCKED_PROG(fin[0]), .FLAGS(flags), .CMD_VALID(cvalid),
    .CMD_OP(cop), .CMD_ADDR(cadr), .CMD_REJECT(crej)
  );
  ffs_spi_host host (
    .clk(clk), .sck(sck), .cs_n(cs_n), .dq(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n)
  );

  // decode pulses and any driven line are caught as they happen
  always @(posedge clk) begin
    if (cvalid === 1'b1) begin
      vcnt++;
      lrej = crej;
    end
    if (dq_oe_n !== 4'hF) oe_seen = 1'b1;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_flags(logic pe, logic e, logic p,
                                           logic [7:0] err);
    return {~pe, e, err[5:3], p, err[1], 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic proto(input int p);
    dual <= (p == 1);
    quad <= (p == 2);
    ln = 1 << p;
    repeat (3) @(posedge clk);
  endtask
  task automatic cmd(input logic [7:0] c, input int lanes);
    host.open_frame();
    host.send({24'h000000, c}, 8, lanes);
  endtask
  // bounded wait for one more decode pulse
  task automatic wait_cmd(input int m);
    for (int k = 0; k < 80 && vcnt == m; k++) @(posedge clk);
    chk("cmd_seen", m + 1, vcnt);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog well past the expected run of about 5700 cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("flags_reset", 8'h80, flags);
    // status bits follow their conditions, register writes ignored
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      fin[8] <= r[0];
      rwb    <= r[1];
      es     <= r[2];
      ps     <= r[3];
      repeat (2) @(posedge clk);
      chk("flags_status", exp_flags(r[0], r[2], r[3], 0),
          flags);
    end
    fin <= 9'h000;
    es  <= 1'b0;
    ps  <= 1'b0;
    $display("test status done");
    // each error source sticks, taints a program command, then clears
    for (int i = 0; i < 8; i++) begin
      fin <= ev[i];
      @(posedge clk);
      fin <= 9'h000;
      repeat (6) @(posedge clk);
      chk("flags_error", 8'h80 | ee[i], flags);
      cmd(8'h06, 1);
      host.close_frame();
      n = vcnt;
      cmd(8'h02, 1);
      wait_cmd(n);
      chk("reject", ee[i] != 0, lrej);
      chk("op_prog", OP_PE, cop);
      host.close_frame();
      cmd(8'h50, 1);
      host.close_frame();
      chk("flags_clear", 8'h80, flags);
    end
    $display("test errors done");
    // flag read repeats in every protocol
    es  <= 1'b1;
    fin <= 9'h080;
    @(posedge clk);
    fin <= 9'h000;
    for (int p = 0; p < 3; p++) begin
      proto(p);
      cmd(8'h70, ln);
      repeat (2) begin
        host.recv(b, ln);
        chk("flag_read", 8'hE0, b);
      end
      host.close_frame();
    end
    proto(0);
    es <= 1'b0;
    cmd(8'h50, 1);
    host.close_frame();
    // configuration word, low byte first, then zero
    r = rnd();
    nvcr <= r[15:0];
    cmd(8'hB5, 1);
    for (int k = 0; k < 3; k++) begin
      host.recv(b, 1);
      chk("nvcr_read", k == 0 ? r[7:0] : k == 1 ? r[15:8] : 8'h00, b);
    end
    host.close_frame();
    $display("test reads done");
    // fast reads report op and address after the dummy count
    for (int i = 0; i < 9; i++) begin
      proto(fp[i]);
      dummy <= fd[i];
      r = rnd();
      n = vcnt;
      cmd(fc[i], ln);
      host.send({8'h00, r[23:0]}, 24, fa[i]);
      host.send(32'h0, fd[i] != 0 ? int'(fd[i]) : (fp[i] == 2 ? 10 : 8), 1);
      wait_cmd(n);
      chk("op_fast", fo[i], cop);
      chk("addr_fast", r[23:0], cadr);
      host.close_frame();
    end
    dummy <= 4'h0;
    // codes not valid in a protocol leave the lines alone
    for (int i = 0; i < 6; i++) begin
      proto(rp[i]);
      n = vcnt;
      oe_seen = 1'b0;
      cmd(rc[i], ln);
      host.recv(b, ln);
      host.close_frame();
      if (rd[i]) chk("first_byte", rc[i] == 8'h70 ? 32'h80 :
                     (`FFS_ID_VALUE >> 16), b);
      chk("lines_driven", rd[i], oe_seen);
      if (!rd[i]) chk("no_cmd", n, vcnt);
    end
    $display("test decode done");
    finish_test();
  end
endmodule
